// file: pkg/spll_cfg.svh
/*
 * constants of the synthesizer control word decoder: addresses, field
 * positions, reset words and timing counts.
 * assumes it is included by bare name wherever these values are used.
 */
`ifndef SPLL_CFG_SVH
`define SPLL_CFG_SVH

////////////////////////////////////////////////////////////////////////
// word layout
`define SPLL_WORD_W 32
`define SPLL_ADDR_HI 2
`define SPLL_ADDR_LO 0
`define SPLL_ADDR_INT 3'h0
`define SPLL_ADDR_REF 3'h2
`define SPLL_ADDR_VCO 3'h3
`define SPLL_ADDR_OUT 3'h4

////////////////////////////////////////////////////////////////////////
// reset words
`define SPLL_REF_RST 32'h00004042
`define SPLL_VCO_RST 32'h0000000b
`define SPLL_OUTDIV_RST 3'h0

////////////////////////////////////////////////////////////////////////
// reference / charge-pump word fields
`define SPLL_LOCK_SPEED 31
`define SPLL_NOISE_HI 30
`define SPLL_NOISE_LO 29
`define SPLL_MUX_HI 28
`define SPLL_MUX_LO 26
`define SPLL_DOUBLER 25
`define SPLL_REF_HALF 24
`define SPLL_R_HI 23
`define SPLL_R_LO 14
`define SPLL_DB 13
`define SPLL_PUMP_HI 12
`define SPLL_PUMP_LO 9
`define SPLL_LOCK_FUNC 8
`define SPLL_LOCK_PREC 7
`define SPLL_POLARITY 6
`define SPLL_POWERDOWN 5
`define SPLL_TRI 4
`define SPLL_RST 3

////////////////////////////////////////////////////////////////////////
// oscillator / clock-divider word fields, then the output word divider field
`define SPLL_VCO_HI 31
`define SPLL_VCO_LO 26
`define SPLL_VASD 25
`define SPLL_VAST 24
`define SPLL_SLIP 18
`define SPLL_MDEL 17
`define SPLL_CLKDIV_MODE_HI 16
`define SPLL_CLKDIV_MODE_LO 15
`define SPLL_CLKDIV_HI 14
`define SPLL_CLKDIV_LO 3
`define SPLL_DIVA_HI 22
`define SPLL_DIVA_LO 20

////////////////////////////////////////////////////////////////////////
// timing
`define SPLL_MUTE_DELAY_CYC 16

`endif

// file: pkg/spll_pkg.sv
/*
 * types of the synthesizer control word decoder.
 * assumes spll_cfg.svh is compiled alongside.
 */
package spll_pkg;
    typedef enum logic [1:0] {
        SPLL_NOISE_LOW_NOISE = 2'h0,
        SPLL_NOISE_RESERVED = 2'h1,
        SPLL_NOISE_LOW_SPUR1 = 2'h2,
        SPLL_NOISE_LOW_SPUR2 = 2'h3
    } spll_noise_t;

    typedef enum logic [1:0] {
        SPLL_CLKDIV_MUTE_DELAY = 2'h0,
        SPLL_CLKDIV_FAST_LOCK = 2'h1,
        SPLL_CLKDIV_PHASE_ADJ = 2'h2,
        SPLL_CLKDIV_RESERVED = 2'h3
    } spll_clkdiv_mode_t;

    typedef enum logic [3:0] {
        SPLL_MUX_TRISTATE = 4'h0,
        SPLL_MUX_HIGH = 4'h1,
        SPLL_MUX_LOW = 4'h2,
        SPLL_MUX_LOCK = 4'h6,
        SPLL_MUX_READBACK = 4'hc
    } spll_mux_t;

    // gray along idle -> settle -> locked
    typedef enum logic [1:0] {
        SPLL_MUTE_IDLE = 2'h0,
        SPLL_MUTE_SETTLE = 2'h1,
        SPLL_MUTE_LOCKED = 2'h3
    } spll_mute_state_t;
endpackage

// file: rtl/spll_serial_rx.sv
/*
 * serial control port receiver: shifts data in msb first on rising
 * clock-pin edges and hands over the whole word on the latch-pin rise.
 * assumes the three pins are asynchronous to clk and that the pin clock
 * is much slower than clk, so every edge survives synchronisation.
 */
`timescale 1ns/1ps
`include "spll_cfg.svh"

module spll_serial_rx #(
    parameter int WORD_W = `SPLL_WORD_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ser_clk_pin,
    input wire logic ser_data_pin,
    input wire logic ser_latch_pin,
    output logic [WORD_W-1:0] word,
    output logic word_valid
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic clk_d;
    logic latch_d;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] next_shift;
    logic [WORD_W-1:0] next_word;
    logic next_valid;

    ////////////////////////////////////////////////////////////////////
    // two flops per pin; only sync[] feeds logic
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= 3'h0;
            sync <= 3'h0;
            clk_d <= 1'b0;
            latch_d <= 1'b0;
        end else begin
            meta <= {ser_latch_pin, ser_data_pin, ser_clk_pin};
            sync <= meta;
            clk_d <= sync[0];
            latch_d <= sync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_shift = shift;
        next_word = word;
        next_valid = 1'b0;
        if (sync[0] && !clk_d) begin
            next_shift = {shift[WORD_W-2:0], sync[1]};
        end
        if (sync[2] && !latch_d) begin
            next_word = shift;
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift <= '0;
            word <= '0;
            word_valid <= 1'b0;
        end else begin
            shift <= next_shift;
            word <= next_word;
            word_valid <= next_valid;
        end
    end
endmodule

// file: rtl/spll_ctrl_regs.sv
/*
 * decoder and holder of the reference/charge-pump control word and the
 * oscillator/clock-divider control word of the synthesizer, with the
 * double buffering tied to the integer/fraction word, the multipurpose
 * output pin and the lock-to-mute delay.
 * assumes a host shifting 32-bit words over the serial control pins and
 * a lock indicator arriving asynchronously from the analog loop.
 */
`timescale 1ns/1ps
`include "spll_cfg.svh"

module spll_ctrl_regs #(
    parameter int MUTE_DELAY_CYC = `SPLL_MUTE_DELAY_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ser_clk_pin,
    input wire logic ser_data_pin,
    input wire logic ser_latch_pin,
    input wire logic lock_indicator_pin,
    input wire logic muxout_select_msb,
    input wire logic readback_bit,
    output logic muxout_o,
    output logic muxout_oe_n,
    output logic lock_detect_speed,
    output spll_pkg::spll_noise_t sigma_delta_noise_mode,
    output logic [2:0] muxout_select,
    output logic ref_doubler_enable,
    output logic ref_half_enable,
    output logic [9:0] ref_divider,
    output logic output_double_buffer_enable,
    output logic [3:0] pump_current_code,
    output logic lock_detect_function,
    output logic lock_detect_precision,
    output logic detector_polarity,
    output logic device_powerdown,
    output logic pump_tristate,
    output logic counter_reset,
    output logic [5:0] osc_manual_select,
    output logic auto_osc_select_disable,
    output logic auto_osc_select_temp_comp,
    output logic cycle_slip_reduce_enable,
    output logic mute_delay_enable,
    output spll_pkg::spll_clkdiv_mode_t clock_divider_mode,
    output logic [11:0] clock_divider_value,
    output logic [2:0] out_divider,
    output logic auto_osc_start,
    output logic mute_until_locked
);
    import spll_pkg::*;

    localparam logic [31:0] REF_RST = `SPLL_REF_RST;
    localparam logic [31:0] VCO_RST = `SPLL_VCO_RST;
    localparam int CNT_W = $clog2(MUTE_DELAY_CYC + 1);

    logic [31:0] word;
    logic word_valid;
    logic [31:0] ref_word;
    logic [31:0] vco_word;
    logic [31:0] next_ref_word;
    logic [31:0] next_vco_word;
    logic [9:0] next_ref_divider;
    logic [3:0] next_pump_current;
    logic [2:0] out_div_pend;
    logic [2:0] next_out_div_pend;
    logic [2:0] next_out_divider;
    logic next_osc_start;
    logic [2:0] addr;
    logic lock_meta;
    logic lock_sync;
    logic next_muxout;
    logic next_oe_n;
    spll_mute_state_t mute_state;
    spll_mute_state_t next_mute_state;
    logic [CNT_W-1:0] mute_cnt;
    logic [CNT_W-1:0] next_mute_cnt;
    logic next_mute;

    spll_serial_rx #(
        .WORD_W(32)
    ) u_rx (
        .clk(clk),
        .srst(srst),
        .ser_clk_pin(ser_clk_pin),
        .ser_data_pin(ser_data_pin),
        .ser_latch_pin(ser_latch_pin),
        .word(word),
        .word_valid(word_valid)
    );

    assign addr = word[`SPLL_ADDR_HI:`SPLL_ADDR_LO];

    ////////////////////////////////////////////////////////////////////
    // word capture and double buffering
    always_comb begin
        next_ref_word = ref_word;
        next_vco_word = vco_word;
        next_ref_divider = ref_divider;
        next_pump_current = pump_current_code;
        next_out_div_pend = out_div_pend;
        next_out_divider = out_divider;
        next_osc_start = 1'b0;
        if (word_valid) begin
            unique case (addr)
                `SPLL_ADDR_REF: next_ref_word = word;
                `SPLL_ADDR_VCO: next_vco_word = word;
                `SPLL_ADDR_OUT: begin
                    next_out_div_pend = word[`SPLL_DIVA_HI:`SPLL_DIVA_LO];
                    if (!ref_word[`SPLL_DB]) begin
                        next_out_divider = word[`SPLL_DIVA_HI:`SPLL_DIVA_LO];
                    end
                end
                `SPLL_ADDR_INT: begin
                    // shadowed fields move to the loop only here
                    next_ref_divider = ref_word[`SPLL_R_HI:`SPLL_R_LO];
                    next_pump_current = ref_word[`SPLL_PUMP_HI:`SPLL_PUMP_LO];
                    next_out_divider = out_div_pend;
                    next_osc_start = !vco_word[`SPLL_VASD];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ref_word <= REF_RST;
            vco_word <= VCO_RST;
            ref_divider <= REF_RST[`SPLL_R_HI:`SPLL_R_LO];
            pump_current_code <= REF_RST[`SPLL_PUMP_HI:`SPLL_PUMP_LO];
            out_div_pend <= `SPLL_OUTDIV_RST;
            out_divider <= `SPLL_OUTDIV_RST;
            auto_osc_start <= 1'b0;
        end else begin
            ref_word <= next_ref_word;
            vco_word <= next_vco_word;
            ref_divider <= next_ref_divider;
            pump_current_code <= next_pump_current;
            out_div_pend <= next_out_div_pend;
            out_divider <= next_out_divider;
            auto_osc_start <= next_osc_start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field outputs straight from the held words
    assign lock_detect_speed = ref_word[`SPLL_LOCK_SPEED];
    assign sigma_delta_noise_mode = spll_noise_t'(ref_word[`SPLL_NOISE_HI:`SPLL_NOISE_LO]);
    assign muxout_select = ref_word[`SPLL_MUX_HI:`SPLL_MUX_LO];
    assign ref_doubler_enable = ref_word[`SPLL_DOUBLER];
    assign ref_half_enable = ref_word[`SPLL_REF_HALF];
    assign output_double_buffer_enable = ref_word[`SPLL_DB];
    assign lock_detect_function = ref_word[`SPLL_LOCK_FUNC];
    assign lock_detect_precision = ref_word[`SPLL_LOCK_PREC];
    assign detector_polarity = ref_word[`SPLL_POLARITY];
    assign device_powerdown = ref_word[`SPLL_POWERDOWN];
    assign pump_tristate = ref_word[`SPLL_TRI];
    assign counter_reset = ref_word[`SPLL_RST];
    assign osc_manual_select = vco_word[`SPLL_VCO_HI:`SPLL_VCO_LO];
    assign auto_osc_select_disable = vco_word[`SPLL_VASD];
    assign auto_osc_select_temp_comp = vco_word[`SPLL_VAST];
    assign cycle_slip_reduce_enable = vco_word[`SPLL_SLIP];
    assign mute_delay_enable = vco_word[`SPLL_MDEL];
    assign clock_divider_mode = spll_clkdiv_mode_t'(vco_word[`SPLL_CLKDIV_MODE_HI:`SPLL_CLKDIV_MODE_LO]);
    assign clock_divider_value = vco_word[`SPLL_CLKDIV_HI:`SPLL_CLKDIV_LO];

    ////////////////////////////////////////////////////////////////////
    // multipurpose pin; codes outside the list drive low
    always_comb begin
        next_muxout = 1'b0;
        next_oe_n = 1'b0;
        unique case ({muxout_select_msb, muxout_select})
            SPLL_MUX_TRISTATE: next_oe_n = 1'b1;
            SPLL_MUX_HIGH: next_muxout = 1'b1;
            SPLL_MUX_LOCK: next_muxout = lock_sync;
            SPLL_MUX_READBACK: next_muxout = readback_bit;
            default: next_muxout = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // lock to mute: with mute_delay_enable set the delay needs lock to hold steady,
    // so a flickering indicator never unmutes; with it clear the first lock cycle does
    always_comb begin
        next_mute_state = mute_state;
        next_mute_cnt = mute_cnt;
        next_mute = 1'b0;
        unique case (mute_state)
            SPLL_MUTE_IDLE: begin
                next_mute_cnt = '0;
                if (lock_sync) begin
                    next_mute_state = mute_delay_enable ? SPLL_MUTE_SETTLE : SPLL_MUTE_LOCKED;
                    next_mute = !mute_delay_enable;
                end
            end
            SPLL_MUTE_SETTLE: begin
                if (!lock_sync) begin
                    next_mute_state = SPLL_MUTE_IDLE;
                end else if (mute_cnt == CNT_W'(MUTE_DELAY_CYC - 1)) begin
                    next_mute_state = SPLL_MUTE_LOCKED;
                    next_mute = 1'b1;
                end else begin
                    next_mute_cnt = mute_cnt + 1'b1;
                end
            end
            SPLL_MUTE_LOCKED: begin
                next_mute = lock_sync;
                if (!lock_sync) begin
                    next_mute_state = SPLL_MUTE_IDLE;
                end
            end
            default: next_mute_state = SPLL_MUTE_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            muxout_o <= 1'b0;
            muxout_oe_n <= 1'b1;
            mute_state <= SPLL_MUTE_IDLE;
            mute_cnt <= '0;
            mute_until_locked <= 1'b0;
        end else begin
            lock_meta <= lock_indicator_pin;
            lock_sync <= lock_meta;
            muxout_o <= next_muxout;
            muxout_oe_n <= next_oe_n;
            mute_state <= next_mute_state;
            mute_cnt <= next_mute_cnt;
            mute_until_locked <= next_mute;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_ref_load;
        @(posedge clk) disable iff (srst)
        (word_valid && addr == `SPLL_ADDR_REF) |=> (ref_word == $past(word));
    endproperty
    a_ref_load: assert property (p_ref_load) else $error("reference word not loaded");

    property p_vco_keep;
        @(posedge clk) disable iff (srst)
        (word_valid && addr != `SPLL_ADDR_VCO) |=> $stable(vco_word);
    endproperty
    a_vco_keep: assert property (p_vco_keep) else $error("oscillator word changed on other address");

    property p_rdiv_buffered;
        @(posedge clk) disable iff (srst)
        !(word_valid && addr == `SPLL_ADDR_INT) |=> $stable(ref_divider) && $stable(pump_current_code);
    endproperty
    a_rdiv_buffered: assert property (p_rdiv_buffered) else $error("buffered field moved early");

    property p_cp_apply;
        @(posedge clk) disable iff (srst)
        (word_valid && addr == `SPLL_ADDR_INT)
            |=> (pump_current_code == $past(ref_word[`SPLL_PUMP_HI:`SPLL_PUMP_LO]));
    endproperty
    a_cp_apply: assert property (p_cp_apply) else $error("pump current not applied");

    property p_outdiv_db;
        @(posedge clk) disable iff (srst)
        (output_double_buffer_enable && !(word_valid && addr == `SPLL_ADDR_INT)) |=> $stable(out_divider);
    endproperty
    a_outdiv_db: assert property (p_outdiv_db) else $error("output divider moved while buffered");

    property p_osc_start;
        @(posedge clk) disable iff (srst)
        auto_osc_start |-> ($past(word_valid) && $past(addr) == `SPLL_ADDR_INT && !auto_osc_select_disable);
    endproperty
    a_osc_start: assert property (p_osc_start) else $error("selection start without cause");

    property p_mux_lock;
        @(posedge clk) disable iff (srst)
        ({muxout_select_msb, muxout_select} == SPLL_MUX_LOCK) |=> (muxout_o == $past(lock_sync)) && !muxout_oe_n;
    endproperty
    a_mux_lock: assert property (p_mux_lock) else $error("pin not showing lock");

    property p_mute_delay;
        @(posedge clk) disable iff (srst)
        (mute_delay_enable && $rose(lock_sync) && mute_state == SPLL_MUTE_IDLE) |=> !mute_until_locked [*3];
    endproperty
    a_mute_delay: assert property (p_mute_delay) else $error("lock passed to mute too soon");
endmodule

// file: dv/spll_host_model.sv
/*
 * host model: shifts 32-bit control words into the serial control pins.
 * assumes the caller sits at a falling clk edge and the pins are
 * synchronised inside the device on the same 25 MHz clock.
 */
`timescale 1ns/1ps

module spll_host_model (
    input wire logic clk,
    output logic ser_clk_pin,
    output logic ser_data_pin,
    output logic ser_latch_pin
);
    // 4 clk per level: the synchronisers need 3, one spare
    localparam int HOLD = 4;

    initial begin
        ser_clk_pin = 1'b0;
        ser_data_pin = 1'b0;
        ser_latch_pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic send(input logic [31:0] w);
        logic [31:0] v;
        v = w;
        if (v[2:0] == 3'h3) begin
            v[23:19] = 5'h00;
        end
        for (int i = 31; i >= 0; i--) begin
            ser_data_pin = v[i];
            repeat (HOLD) @(negedge clk);
            ser_clk_pin = 1'b1;
            repeat (HOLD) @(negedge clk);
            ser_clk_pin = 1'b0;
        end
        // serial clock stands still; data no longer shows the last bit
        ser_data_pin = ~v[0];
        ser_latch_pin = 1'b1;
        repeat (HOLD) @(negedge clk);
        ser_latch_pin = 1'b0;
        repeat (HOLD) @(negedge clk);
    endtask
endmodule

// file: dv/test_synth_pll_control_regs_2_3.sv
/*
 * testbench of the control word decoder: host model writes words,
 * tests compare the decoded outputs with the written fields.
 * assumes spll_pkg and spll_cfg.svh are compiled alongside.
 */
`timescale 1ns/1ps

module test_synth_pll_control_regs_2_3;
    import spll_pkg::*;

    logic clk, srst, ser_clk_pin, ser_data_pin, ser_latch_pin;
    logic lock_indicator_pin, muxout_select_msb, readback_bit;
    logic muxout_o, muxout_oe_n, lock_detect_speed, ref_doubler_enable, ref_half_enable;
    logic output_double_buffer_enable, lock_detect_function, lock_detect_precision;
    logic detector_polarity, device_powerdown, pump_tristate, counter_reset;
    logic auto_osc_select_disable, auto_osc_select_temp_comp, cycle_slip_reduce_enable;
    logic mute_delay_enable, auto_osc_start, mute_until_locked;
    logic [2:0] muxout_select, out_divider;
    logic [9:0] ref_divider;
    logic [3:0] pump_current_code;
    logic [5:0] osc_manual_select;
    logic [11:0] clock_divider_value;
    spll_noise_t sigma_delta_noise_mode;
    spll_clkdiv_mode_t clock_divider_mode;
    int err_count = 0;
    int total_checks = 0;
    int pulses = 0;
    logic [31:0] cur_vco = 32'h0000000b;
    logic [31:0] w;
    logic [13:0] held;

    wire [31:0] obs_ref = {lock_detect_speed, sigma_delta_noise_mode, muxout_select, ref_doubler_enable,
        ref_half_enable, 10'h000, output_double_buffer_enable, 4'h0, lock_detect_function,
        lock_detect_precision, detector_polarity, device_powerdown, pump_tristate, counter_reset, 3'h0};
    wire [31:0] obs_vco = {osc_manual_select, auto_osc_select_disable, auto_osc_select_temp_comp, 5'h00,
        cycle_slip_reduce_enable, mute_delay_enable, clock_divider_mode, clock_divider_value, 3'h0};

    spll_ctrl_regs #(.MUTE_DELAY_CYC(4)) u_dut (.clk, .srst, .ser_clk_pin, .ser_data_pin,
        .ser_latch_pin, .lock_indicator_pin, .muxout_select_msb, .readback_bit, .muxout_o,
        .muxout_oe_n, .lock_detect_speed, .sigma_delta_noise_mode, .muxout_select,
        .ref_doubler_enable, .ref_half_enable, .ref_divider, .output_double_buffer_enable,
        .pump_current_code, .lock_detect_function, .lock_detect_precision, .detector_polarity,
        .device_powerdown, .pump_tristate, .counter_reset, .osc_manual_select,
        .auto_osc_select_disable, .auto_osc_select_temp_comp, .cycle_slip_reduce_enable,
        .mute_delay_enable, .clock_divider_mode, .clock_divider_value, .out_divider,
        .auto_osc_start, .mute_until_locked);

    spll_host_model u_host (.clk, .ser_clk_pin, .ser_data_pin, .ser_latch_pin);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (auto_osc_start === 1'b1) begin
            pulses++;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] v);
        u_host.send(v);
        if (v[2:0] == 3'h3) begin
            cur_vco = v;
        end
    endtask

    // integer/fraction write: one selection start only while auto select is on
    task automatic wr_int;
        int p;
        p = pulses;
        u_host.send(32'h0);
        check(32'(pulses - p), 32'(!cur_vco[25]));
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        lock_indicator_pin = 1'b0;
        muxout_select_msb = 1'b0;
        readback_bit = 1'b0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check(obs_ref, 32'h00004042 & 32'hff0021f8);
        check(obs_vco, 32'h0000000b & 32'hff07fff8);
        check(32'({ref_divider, pump_current_code, out_divider, muxout_oe_n}), 32'({10'h1, 4'h0, 3'h0, 1'b1}));
        held = {10'h1, 4'h0};
        for (int i = 0; i < 4; i++) begin
            w = {i[0], i[1:0], 3'(i + 5), i[1], i[0], 10'(1023 - i), 1'b0, 4'(15 - i),
                i[0], i[1], ~i[0], i[1], i[0], ~i[1], 3'h2};
            wr(w);
            check(obs_ref, w & 32'hff0021f8);
            check(32'({ref_divider, pump_current_code}), 32'(held));
            wr_int;
            held = {w[23:14], w[12:9]};
            check(32'({ref_divider, pump_current_code}), 32'(held));
        end
        for (int i = 0; i < 4; i++) begin
            wr({6'(63 - i * 21), i[0], i[1], 5'h00, i[1], i[0], i[1:0], 12'(i == 0 ? 4095 : i), 3'h3});
            check(obs_vco, cur_vco & 32'hff07fff8);
            wr_int;
        end
        // unmapped addresses must leave both words alone
        for (int a = 5; a <= 8; a++) begin
            wr({29'h1fffffff, 3'(a == 8 ? 1 : a)});
        end
        check(obs_ref, w & 32'hff0021f8);
        check(obs_vco, cur_vco & 32'hff07fff8);
        wr({9'h0, 3'h5, 17'h0, 3'h4});
        check(32'(out_divider), 32'h5);
        wr(w | 32'h00002000);
        check(32'(output_double_buffer_enable), 32'h1);
        wr({9'h0, 3'h3, 17'h0, 3'h4});
        check(32'(out_divider), 32'h5);
        wr_int;
        check(32'(out_divider), 32'h3);
        // lock on the pin with the mute delay off, then on
        wr(32'h18004042);
        wr(32'h0000000b);
        lock_indicator_pin = 1'b1;
        repeat (4) @(negedge clk);
        check(32'({muxout_o, muxout_oe_n, mute_until_locked}), 32'h5);
        lock_indicator_pin = 1'b0;
        repeat (6) @(negedge clk);
        check(32'({muxout_o, muxout_oe_n, mute_until_locked}), 32'h0);
        wr(32'h0002000b);
        lock_indicator_pin = 1'b1;
        repeat (4) @(negedge clk);
        check(32'(mute_until_locked), 32'h0);
        repeat (8) @(negedge clk);
        check(32'(mute_until_locked), 32'h1);
        lock_indicator_pin = 1'b0;
        repeat (6) @(negedge clk);
        check(32'(mute_until_locked), 32'h0);
        // selector 1100 shows the readback bit, high then low, with the pin driven
        muxout_select_msb = 1'b1;
        wr(32'h10004042);
        readback_bit = 1'b1;
        repeat (3) @(negedge clk);
        check(32'({muxout_o, muxout_oe_n}), 32'h2);
        readback_bit = 1'b0;
        repeat (3) @(negedge clk);
        check(32'({muxout_o, muxout_oe_n}), 32'h0);
        muxout_select_msb = 1'b0;
        // selector 0001 drives the pin high
        wr(32'h04004042);
        check(32'({muxout_o, muxout_oe_n}), 32'h2);
        wr(32'h00004042);
        check(32'(muxout_oe_n), 32'h1);
        give_verdict;
    end

    // roughly 8000 cycles expected; the limit leaves ample room
    initial begin
        #1600000;
        err_count++;
        give_verdict;
    end
endmodule
